//--- src/dcc_pkg.sv
package dcc_pkg;

	// special-function register map
	localparam logic [7:0] DCC_ZERO_CTRL_ADDR = 8'h9B;
	localparam logic [3:0] DCC_ZERO_CTRL_PAGE = 4'h0;
	localparam logic [7:0] DCC_CTRL_RESET     = 8'h00;

	// field positions in a control register
	localparam int DCC_EN_BIT   = 7;
	localparam int DCC_OUT_BIT  = 6;
	localparam int DCC_RISE_BIT = 5;
	localparam int DCC_FALL_BIT = 4;
	localparam int DCC_HYP_LSB  = 2;
	localparam int DCC_HYN_LSB  = 0;

	// hysteresis codes
	typedef enum logic [1:0] {
		DCC_HYS_OFF,
		DCC_HYS_5MV,
		DCC_HYS_10MV,
		DCC_HYS_20MV
	} dcc_hys_t;

	// per comparator analog settings
	typedef struct packed {
		logic     enable;
		dcc_hys_t hys_pos;
		dcc_hys_t hys_neg;
	} dcc_ana_cfg_t;

	// special-function bus request
	typedef struct packed {
		logic [3:0] page;
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} dcc_sfr_req_t;

endpackage

//--- src/dcc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE1] two comparators share identical control and status logic
// [RULE2] each comparator has its own reset and wake capability setting; only the wake setting is built here (FIRST_CAN_WAKE, SECOND_CAN_WAKE)
// [RULE3] each offers a clock-latched output and a raw output for pins
// [RULE4] first raw output stays valid with the system clock stopped
// [RULE5] input mux and response time are programmable per comparator
// [RULE6] software enables a comparator before trusting outputs or flags
// [RULE7] clearing enable powers the comparator down
// [RULE8] software clears edge flags after enabling or changing modes
// [RULE9] bit 7 is enable, read/write, resets to 0
// [RULE10] bit 6 reads the comparator output state
// [RULE11] bit 5 sets on rising edge, cleared only by writing 0
// [RULE12] bit 4 sets on falling edge, cleared only by writing 0
// [RULE13] bits 3-2 select positive hysteresis off, 5, 10, 20 mV
// [RULE14] bits 1-0 select negative hysteresis with the same codes
// [RULE15] first control register at address 0x9B page 0, resets to zero
// [RULE16] first comparator can wake from suspend and sleep
// [RULE17] latched output is raw through two flops; edges come from it
// [RULE18] an edge in the clearing cycle leaves its flag set
module dcc_top
	import dcc_pkg::*;
#(
	parameter logic [7:0] SECOND_CTRL_ADDR = 8'h9D,
	parameter logic [3:0] SECOND_CTRL_PAGE = 4'h0,
	parameter logic [3:0] MUX_PAGE         = 4'h0,
	parameter logic [7:0] FIRST_MUX_ADDR   = 8'h9F,
	parameter logic [7:0] SECOND_MUX_ADDR  = 8'h9E,
	parameter logic [7:0] FIRST_MODE_ADDR  = 8'h9C,
	parameter logic [7:0] SECOND_MODE_ADDR = 8'h9A,
	parameter bit         FIRST_CAN_WAKE   = 1'b1,
	parameter bit         SECOND_CAN_WAKE  = 1'b0
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// special-function register port
	input  wire dcc_sfr_req_t sfr_req_i,
	input  wire logic         sfr_wr_en_i,
	output logic [7:0]        sfr_rdata_o,
	// analog comparator raw results
	input  wire logic [1:0]   raw_result_i,
	// analog settings toward the front end
	output dcc_ana_cfg_t      ana_cfg_o [2],
	output logic [7:0]        input_mux_o [2],
	output logic [1:0]        resp_mode_o [2],
	// pin outputs
	output logic [1:0]        latched_out_o,
	output logic [1:0]        raw_out_o,
	// power management
	output logic              wake_req_o
);

	localparam int NCMP = 2;

	// elaboration guard; the decode below names exactly two comparators
	if (NCMP != 2) begin : g_ncmp_check
		$error("dcc_top serves exactly two comparators");
	end

	// decode helper, used for every register
	function automatic logic hit(input dcc_sfr_req_t r,
		input logic [3:0] pg, input logic [7:0] ad);
		hit = (r.page == pg) && (r.addr == ad);
	endfunction

	logic [1:0]   en_q, en_d, rise_q, rise_d, fall_q, fall_d;
	logic [1:0]   sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
	logic [1:0]   latched_q, latched_d;
	dcc_hys_t     hyp_q [NCMP], hyp_d [NCMP], hyn_q [NCMP], hyn_d [NCMP];
	logic [7:0]   mux_q [NCMP], mux_d [NCMP];
	logic [1:0]   resp_q [NCMP], resp_d [NCMP];
	logic [7:0]   rdata_d, rdata_q;
	logic [1:0]   wake_ok;
	logic         wake_d, wake_q;
	logic [1:0]   ctl_wr, mux_wr, mode_wr, rise_ev, fall_ev;

	assign wake_ok = {SECOND_CAN_WAKE, FIRST_CAN_WAKE}; // [RULE2]

	// write strobes per comparator; first control is fixed at 0x9B
	always_comb begin
		ctl_wr[0]  = sfr_wr_en_i && hit(sfr_req_i, DCC_ZERO_CTRL_PAGE,
			DCC_ZERO_CTRL_ADDR); // [RULE15]
		ctl_wr[1]  = sfr_wr_en_i && hit(sfr_req_i, SECOND_CTRL_PAGE,
			SECOND_CTRL_ADDR);
		mux_wr[0]  = sfr_wr_en_i && hit(sfr_req_i, MUX_PAGE, FIRST_MUX_ADDR);
		mux_wr[1]  = sfr_wr_en_i && hit(sfr_req_i, MUX_PAGE, SECOND_MUX_ADDR);
		mode_wr[0] = sfr_wr_en_i && hit(sfr_req_i, MUX_PAGE, FIRST_MODE_ADDR);
		mode_wr[1] = sfr_wr_en_i && hit(sfr_req_i, MUX_PAGE,
			SECOND_MODE_ADDR);
	end

	// synchroniser, edge detect and control next state
	always_comb begin
		sync1_d = raw_result_i;
		sync2_d = sync1_q; // [RULE17]
		prev_d  = sync2_q;
		for (int i = 0; i < NCMP; i++) begin
			// edges only count while powered; a disabled comparator is quiet
			rise_ev[i] = en_q[i] && sync2_q[i] && !prev_q[i]; // [RULE17]
			fall_ev[i] = en_q[i] && !sync2_q[i] && prev_q[i];
			en_d[i]   = en_q[i];
			rise_d[i] = rise_q[i];
			fall_d[i] = fall_q[i];
			hyp_d[i]  = hyp_q[i];
			hyn_d[i]  = hyn_q[i];
			mux_d[i]  = mux_q[i];
			resp_d[i] = resp_q[i];
			if (ctl_wr[i]) begin
				en_d[i]   = sfr_req_i.wdata[DCC_EN_BIT]; // [RULE9] [RULE7]
				rise_d[i] = sfr_req_i.wdata[DCC_RISE_BIT];
				fall_d[i] = sfr_req_i.wdata[DCC_FALL_BIT];
				hyp_d[i]  = dcc_hys_t'(sfr_req_i.wdata[DCC_HYP_LSB +: 2]); // [RULE13]
				hyn_d[i]  = dcc_hys_t'(sfr_req_i.wdata[DCC_HYN_LSB +: 2]); // [RULE14]
			end
			if (mux_wr[i]) begin
				mux_d[i] = sfr_req_i.wdata; // [RULE5]
			end
			if (mode_wr[i]) begin
				resp_d[i] = sfr_req_i.wdata[1:0]; // [RULE5]
			end
			// set wins over software clear
			if (rise_ev[i]) begin
				rise_d[i] = 1'b1; // [RULE11] [RULE18]
			end
			if (fall_ev[i]) begin
				fall_d[i] = 1'b1; // [RULE12] [RULE18]
			end
		end
		// pin copy registered from next values so it lines up with sync2_q
		latched_d = sync2_d & en_d; // [RULE3]
	end

	// read mux and wake request
	always_comb begin
		rdata_d = 8'h00;
		for (int i = 0; i < NCMP; i++) begin
			if (hit(sfr_req_i, i == 0 ? DCC_ZERO_CTRL_PAGE : SECOND_CTRL_PAGE,
				i == 0 ? DCC_ZERO_CTRL_ADDR : SECOND_CTRL_ADDR)) begin
				rdata_d = {en_q[i], sync2_q[i] & en_q[i], rise_q[i],
					fall_q[i], hyp_q[i], hyn_q[i]}; // [RULE10] [RULE1]
			end
			if (hit(sfr_req_i, MUX_PAGE,
				i == 0 ? FIRST_MUX_ADDR : SECOND_MUX_ADDR)) begin
				rdata_d = mux_q[i];
			end
			if (hit(sfr_req_i, MUX_PAGE,
				i == 0 ? FIRST_MODE_ADDR : SECOND_MODE_ADDR)) begin
				rdata_d = {6'h00, resp_q[i]};
			end
		end
		// clocked wake is a fallback; the raw pin wakes with no clock
		wake_d = |(wake_ok & en_q & (rise_ev | fall_ev)); // [RULE16]
	end

	// state registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_q    <= 2'h0;
			rise_q  <= 2'h0;
			fall_q  <= 2'h0;
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			prev_q  <= 2'h0;
			latched_q <= 2'h0;
			rdata_q <= DCC_CTRL_RESET;
			wake_q  <= 1'b0;
			for (int i = 0; i < NCMP; i++) begin
				hyp_q[i]  <= DCC_HYS_OFF;
				hyn_q[i]  <= DCC_HYS_OFF;
				mux_q[i]  <= 8'h00;
				resp_q[i] <= 2'h0;
			end
		end else begin
			en_q    <= en_d;
			rise_q  <= rise_d;
			fall_q  <= fall_d;
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q  <= prev_d;
			latched_q <= latched_d;
			rdata_q <= rdata_d;
			wake_q  <= wake_d;
			for (int i = 0; i < NCMP; i++) begin
				hyp_q[i]  <= hyp_d[i];
				hyn_q[i]  <= hyn_d[i];
				mux_q[i]  <= mux_d[i];
				resp_q[i] <= resp_d[i];
			end
		end
	end

	// outputs; raw path is deliberately combinational so it needs no clock
	always_comb begin
		for (int i = 0; i < NCMP; i++) begin
			ana_cfg_o[i]   = '{enable: en_q[i], hys_pos: hyp_q[i],
				hys_neg: hyn_q[i]}; // [RULE7]
			input_mux_o[i] = mux_q[i];
			resp_mode_o[i] = resp_q[i];
		end
	end
	assign raw_out_o     = raw_result_i & en_q; // [RULE3] [RULE4]
	assign latched_out_o = latched_q; // [RULE3]
	assign sfr_rdata_o   = rdata_q;
	assign wake_req_o    = wake_q;

	// assertions
	sequence s_rise(i);
		sync2_q[i] && !prev_q[i] && en_q[i];
	endsequence

	chk_rise_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_rise(0) |=> rise_q[0]) // [RULE11]
		else $error("rising edge did not set flag");
	chk_fall_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!sync2_q[1] && prev_q[1] && en_q[1]) |=> fall_q[1]) // [RULE12]
		else $error("falling edge did not set flag");
	chk_flag_hw_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rise_q[0] && !ctl_wr[0]) |=> rise_q[0]) // [RULE11]
		else $error("rise flag cleared by hardware");
	chk_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ctl_wr[0] && rise_ev[0]) |=> rise_q[0]) // [RULE18]
		else $error("edge lost in clearing cycle");
	chk_sync_two_stage: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		en_q[0] [*3] |-> latched_out_o[0] == $past(raw_result_i[0], 2)) // [RULE17]
		else $error("latched output not two cycles behind");
	chk_enable_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ctl_wr[0] |=> en_q[0] == $past(sfr_req_i.wdata[7])) // [RULE9]
		else $error("enable bit not written");
	chk_disable_power: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!en_q[1] |-> !ana_cfg_o[1].enable && !raw_out_o[1]) // [RULE7]
		else $error("disabled comparator still active");
	chk_hys_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ctl_wr[1] |=> hyp_q[1] == $past(sfr_req_i.wdata[3:2])
		&& hyn_q[1] == $past(sfr_req_i.wdata[1:0])) // [RULE13] [RULE14]
		else $error("hysteresis field not written");
	chk_out_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!sfr_wr_en_i && hit(sfr_req_i, 4'h0, 8'h9B)) |=>
		sfr_rdata_o[6] == $past(sync2_q[0] & en_q[0])) // [RULE10] [RULE15]
		else $error("output state flag read wrong");

endmodule // dcc_top

`default_nettype wire

//--- bench/dcc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_front_model (
	// clock and power from the block
	input  wire logic       clk_i,
	input  wire logic [1:0] en_i,
	// analog levels and response speed
	input  wire logic [1:0] level_i,
	input  wire logic       slow_i,
	// raw comparator results
	output logic [1:0]      raw_o
);
	logic [1:0] lag_q;
	// slow mode settles a cycle late, like a long response time
	always_ff @(posedge clk_i) lag_q <= level_i;
	// a powered-down comparator drives low, never its last value
	assign raw_o = en_i & (slow_i ? lag_q : level_i);
endmodule // dcc_front_model
`default_nettype wire

//--- bench/dcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb;
	import dcc_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_n_i = 1'b0;
	logic         sfr_wr_en_i = 1'b0;
	logic         slow = 1'b0;
	dcc_sfr_req_t sfr_req_i = '0;
	logic [1:0]   level = 2'h0;
	logic [1:0]   raw, latched_out, raw_out, resp [2];
	logic [7:0]   rdata, mux [2];
	dcc_ana_cfg_t ana_cfg [2];
	logic         wake;
	int           num_errors = 0, checks = 0, seed = 61, cycles = 0;
	int           wakes = 0;
	logic [7:0]   addr_tb [2] = '{DCC_ZERO_CTRL_ADDR, 8'h9D};
	logic [7:0]   mux_tb [2] = '{8'h9F, 8'h9E};
	logic [7:0]   mode_tb [2] = '{8'h9C, 8'h9A};
	// reference model of both comparators, kept in plain integers
	int           m_en [2] = '{0, 0};
	int           m_lvl [2] = '{0, 0};
	int           m_rise [2] = '{0, 0};
	int           m_fall [2] = '{0, 0};
	int           m_hys [2] = '{0, 0};
	int           m_mux [2] = '{0, 0};
	int           m_mode [2] = '{0, 0};
	int           wake_m [$];
	// clock, wake pulse counter and hang guard
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (wake === 1'b1) wakes++;
		if (cycles == 2000) begin
			num_errors++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end
	dcc_top i_dcc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sfr_req_i(sfr_req_i), .sfr_wr_en_i(sfr_wr_en_i),
		.sfr_rdata_o(rdata), .raw_result_i(raw), .ana_cfg_o(ana_cfg),
		.input_mux_o(mux), .resp_mode_o(resp),
		.latched_out_o(latched_out), .raw_out_o(raw_out),
		.wake_req_o(wake));
	dcc_front_model i_dcc_front_model (.clk_i(clk_i),
		.en_i({ana_cfg[1].enable, ana_cfg[0].enable}),
		.level_i(level), .slow_i(slow), .raw_o(raw));
	task automatic end_of_test();
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// write strobe lasts one cycle, driven off the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req_i.addr = a;
		sfr_req_i.wdata = d;
		sfr_wr_en_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_en_i = 1'b0;
		@(negedge clk_i);
	endtask
	// read data lags the address by one registered cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		sfr_req_i.addr = a;
		repeat (2) @(negedge clk_i);
		chk(rdata, exp, what);
	endtask
	// expected control register image; output state reads 0 when off
	function automatic logic [7:0] m_ctl(input int i);
		m_ctl = 8'((m_en[i] << 7) | ((m_en[i] & m_lvl[i]) << 6)
			| (m_rise[i] << 5) | (m_fall[i] << 4) | m_hys[i]);
	endfunction
	// control write into design and model; bit 6 is read-only
	task automatic m_wr_ctl(input int i, input logic [7:0] d);
		wr(addr_tb[i], d);
		m_en[i] = d[7];
		m_rise[i] = d[5];
		m_fall[i] = d[4];
		m_hys[i] = d[3:0];
	endtask
	// move one analog level; edges count only while enabled
	task automatic set_lvl(input int i, input int v);
		if (m_en[i] != 0 && v > m_lvl[i]) m_rise[i] = 1;
		if (m_en[i] != 0 && v < m_lvl[i]) m_fall[i] = 1;
		// only the first comparator may wake the device
		if (m_en[i] != 0 && v != m_lvl[i] && i == 0) wake_m.push_back(i);
		level[i] = v[0];
		m_lvl[i] = v;
		repeat (6) @(negedge clk_i);
	endtask
	// pin outputs, power and wake count against the model
	task automatic chk_pins(input int i);
		int s;
		s = m_en[i] & m_lvl[i];
		chk({6'h0, latched_out[i], raw_out[i]}, 8'(s * 3), "pins");
		chk({7'h0, ana_cfg[i].enable}, 8'(m_en[i]), "power");
		chk(8'(wakes), 8'(wake_m.size()), "wake");
	endtask
	initial begin
		logic [3:0] h;
		logic [7:0] d;
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		@(negedge clk_i);
		rd(DCC_ZERO_CTRL_ADDR, m_ctl(0), "reset value");
		rd(8'h55, 8'h00, "unmapped");
		// a write on another page must not reach the control register
		sfr_req_i.page = 4'h1;
		wr(DCC_ZERO_CTRL_ADDR, 8'hFF);
		rd(DCC_ZERO_CTRL_ADDR, 8'h00, "other page");
		sfr_req_i.page = DCC_ZERO_CTRL_PAGE;
		rd(DCC_ZERO_CTRL_ADDR, m_ctl(0), "page guard");
		// same sequence on both comparators, second one answering slowly
		for (int i = 0; i < 2; i++) begin
			slow = i[0];
			m_wr_ctl(i, 8'h80);
			m_wr_ctl(i, 8'h80);
			rd(addr_tb[i], m_ctl(i), "enable");
			chk_pins(i);
			set_lvl(i, 1);
			chk_pins(i);
			rd(addr_tb[i], m_ctl(i), "rise flag");
			m_wr_ctl(i, 8'h80);
			rd(addr_tb[i], m_ctl(i), "rise clear");
			set_lvl(i, 0);
			chk_pins(i);
			rd(addr_tb[i], m_ctl(i), "fall flag");
			for (int c = 0; c < 4; c++) begin
				h = {c[1:0], 2'($random(seed))};
				// bit 6 written high must be ignored
				m_wr_ctl(i, 8'hC0 | {4'h0, h});
				rd(addr_tb[i], m_ctl(i), "hys reg");
				chk({4'h0, ana_cfg[i].hys_pos, ana_cfg[i].hys_neg},
					8'(m_hys[i]), "hys cfg");
			end
			// input select and response time registers
			d = 8'($random(seed));
			wr(mux_tb[i], d);
			wr(mode_tb[i], d);
			m_mux[i] = d;
			m_mode[i] = d & 3;
			rd(mux_tb[i], 8'(m_mux[i]), "mux reg");
			rd(mode_tb[i], 8'(m_mode[i]), "mode reg");
			chk(mux[i], 8'(m_mux[i]), "mux out");
			chk({6'h0, resp[i]}, 8'(m_mode[i]), "mode out");
			m_wr_ctl(i, 8'h00);
			set_lvl(i, 1);
			chk_pins(i);
			rd(addr_tb[i], m_ctl(i), "off reg");
			set_lvl(i, 0);
		end
		// edge and clearing write land on one clock edge: the edge wins
		slow = 1'b0;
		m_wr_ctl(0, 8'h80);
		level[0] = 1'b1;
		repeat (2) @(negedge clk_i);
		wr(addr_tb[0], 8'h80);
		m_lvl[0] = 1;
		m_rise[0] = 1;
		wake_m.push_back(0);
		rd(addr_tb[0], m_ctl(0), "set beats clear");
		chk_pins(0);
		set_lvl(0, 0);
		chk_pins(0);
		// second reset in mid-run brings every register back to zero
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		foreach (m_en[k]) begin
			m_en[k] = 0;
			m_rise[k] = 0;
			m_fall[k] = 0;
			m_hys[k] = 0;
			m_mux[k] = 0;
			m_mode[k] = 0;
		end
		@(negedge clk_i);
		rd(addr_tb[0], m_ctl(0), "reset again");
		rd(addr_tb[1], m_ctl(1), "second reset");
		chk(mux[1], 8'(m_mux[1]), "mux reset");
		chk({6'h0, resp[0]}, 8'(m_mode[0]), "mode reset");
		chk_pins(0);
		end_of_test();
	end
endmodule // dcc_top_tb
`default_nettype wire
